/* core/pwr_mode_pkg.sv */
// Constants shared by the reader power and mode controller.
// Assumes a 100 MHz system clock and control bits handed in as plain ports.
package pwr_mode_pkg;
    // Operation control word layout
    localparam int          OPC_W         = 8;
    localparam int          OPC_EN_BIT    = 7;
    localparam int          OPC_RX_BIT    = 6;
    localparam int          OPC_TX_BIT    = 3;
    localparam int          OPC_WU_BIT    = 2;
    localparam logic [7:0]  OPC_RESET     = 8'h00;
    localparam logic [7:0]  OPC_WU_ONLY   = 8'h04;
    // Voltage and measurement widths
    localparam int          MV_W          = 12;
    localparam int          MEAS_W        = 8;
    localparam logic [11:0] REG_DROP_MV   = 12'h0fa;   // 250 mV below supply
    localparam logic [11:0] REG_MV_RESET  = 12'h000;
    localparam logic [7:0]  CAP_REF_RESET = 8'h00;
    // Load settle time before sampling the supply
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          LOAD_SETTLE_NS = 1000;
    localparam int          LOAD_SETTLE_CYC = (LOAD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  LOAD_CNT_LAST = 8'(LOAD_SETTLE_CYC - 1);
    // Wake-up timer
    localparam int          WU_PER_W      = 8;
    // Controller clock divider
    localparam logic [2:0]  DIV_RESET     = 3'h0;
    // Operating modes and regulator adjust states
    typedef enum logic [1:0] {MODE_PWRDN, MODE_READY, MODE_WAKEUP} op_mode_t;
    typedef enum logic [0:0] {ADJ_IDLE, ADJ_LOAD} adj_state_t;
endpackage

/* core/reader_power_mode_control.sv */
// Operating mode, oscillator, regulator and low-power detect control.
// Assumes all inputs synchronous to clk_sys; analog results arrive as ports.
// How it works
// - Reset clears control word, power-down mode
// - Control writes accepted in power-down too
// - Enable bit 7 runs oscillator, regulators
// - Pulse interrupt once oscillator is stable
// - Boost gain until amplitude criterion met
// - High bit rate demands higher crystal
// - Controller clock output, divider selected
// - Receiver and transmitter enables independent
// - Wake bit alone enters wake-up mode
// - Measurement differing from reference interrupts
// - Capacitive reference stored, threshold compare
// - Adjust command sets supply minus 250mV
// - Regulated voltage also directly writable
// - Peer and collision field thresholds
// - Reset at power-up and supply low
`timescale 1ns/100ps
`default_nettype none
module reader_power_mode_control
    import pwr_mode_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              supply_low,
    input  wire logic              opc_wr,
    input  wire logic [OPC_W-1:0]  opc_wdata,
    input  wire logic              osc_amp_ok,
    input  wire logic              xtal_27m,
    input  wire logic              very_high_bit_rate,
    input  wire logic [1:0]        mcu_clk_sel,
    input  wire logic              reg_adjust_cmd,
    input  wire logic              reg_wr,
    input  wire logic [MV_W-1:0]   reg_wdata,
    input  wire logic [MV_W-1:0]   vdd_mv,
    input  wire logic              rc_tick,
    input  wire logic [WU_PER_W-1:0] wake_period,
    input  wire logic              meas_done,
    input  wire logic              cap_cal_cmd,
    input  wire logic [MEAS_W-1:0] cap_val,
    input  wire logic [MEAS_W-1:0] cap_thr,
    input  wire logic [MEAS_W-1:0] phase_val,
    input  wire logic [MEAS_W-1:0] phase_ref,
    input  wire logic [MEAS_W-1:0] amp_val,
    input  wire logic [MEAS_W-1:0] amp_ref,
    input  wire logic [MEAS_W-1:0] delta_thr,
    input  wire logic [MEAS_W-1:0] field_level,
    input  wire logic [MEAS_W-1:0] peer_thr,
    input  wire logic [MEAS_W-1:0] coll_thr,
    output logic                   por_rst_r,
    output logic [OPC_W-1:0]       opc_r,
    output op_mode_t               mode_r,
    output logic                   osc_on_r,
    output logic                   reg_on_r,
    output logic                   gm_boost_r,
    output logic                   osc_stable_r,
    output logic                   irq_osc_r,
    output logic                   xtal_err_r,
    output logic                   mcu_clk_r,
    output logic                   rx_on_r,
    output logic                   tx_on_r,
    output logic                   load_max_r,
    output logic [MV_W-1:0]        reg_mv_r,
    output logic                   meas_req_r,
    output logic [MEAS_W-1:0]      cap_ref_r,
    output logic                   irq_wake_r,
    output logic                   peer_det_r,
    output logic                   coll_det_r
);
    op_mode_t    mode_nxt;     // Mode decoded from control word
    adj_state_t  adj_r;        // Regulator adjust state
    logic [7:0]  load_cnt_r;   // Settle counter under max load
    logic [2:0]  div_r;        // Controller clock divider
    logic        stable_d_r;   // Previous stable flag
    logic        cap_hit;      // Capacitive threshold exceeded
    logic        phase_hit;    // Phase differs from reference
    logic        amp_hit;      // Amplitude differs from reference
    logic [MEAS_W:0] cap_lim;  // Reference plus threshold
    wake_if      wk ();        // Link to wake-up timer

    // Brown-out flag, held at power-up
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            por_rst_r <= 1'b1;
        end else begin
            por_rst_r <= supply_low;
        end
    end

    // Control word; writes allowed in every mode
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            opc_r <= OPC_RESET;
        end else if (supply_low) begin
            opc_r <= OPC_RESET;
        end else if (opc_wr) begin
            opc_r <= opc_wdata;
        end
    end

    // Mode decode
    always_comb begin
        if (opc_r[OPC_EN_BIT]) begin
            mode_nxt = MODE_READY;
        end else if (opc_r == OPC_WU_ONLY) begin
            mode_nxt = MODE_WAKEUP;
        end else begin
            mode_nxt = MODE_PWRDN;
        end
    end

    // Mode register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_r <= MODE_PWRDN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Oscillator and regulators follow the enable bit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            osc_on_r <= 1'b0;
            reg_on_r <= 1'b0;
        end else begin
            osc_on_r <= opc_r[OPC_EN_BIT];
            reg_on_r <= opc_r[OPC_EN_BIT];
        end
    end

    // Start-up: boosted gain until amplitude is good
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            osc_stable_r <= 1'b0;
            gm_boost_r   <= 1'b0;
        end else if (!osc_on_r) begin
            osc_stable_r <= 1'b0;
            gm_boost_r   <= 1'b0;
        end else if (osc_amp_ok) begin
            osc_stable_r <= 1'b1;
            gm_boost_r   <= 1'b0;
        end else begin
            gm_boost_r   <= !osc_stable_r;
        end
    end

    // Stable interrupt on rising edge
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stable_d_r <= 1'b0;
            irq_osc_r  <= 1'b0;
        end else begin
            stable_d_r <= osc_stable_r;
            irq_osc_r  <= osc_stable_r && !stable_d_r;
        end
    end

    // Crystal check for high bit rate framing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            xtal_err_r <= 1'b0;
        end else begin
            xtal_err_r <= very_high_bit_rate && !xtal_27m;
        end
    end

    // Controller clock: off, or clk divided by 2, 4, 8
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_r     <= DIV_RESET;
            mcu_clk_r <= 1'b0;
        end else if (!osc_stable_r || mcu_clk_sel == 2'h0) begin
            div_r     <= DIV_RESET;
            mcu_clk_r <= 1'b0;
        end else begin
            div_r     <= div_r + 3'h1;
            case (mcu_clk_sel)
                2'h1:    mcu_clk_r <= div_r[0];
                2'h2:    mcu_clk_r <= div_r[1];
                default: mcu_clk_r <= div_r[2];
            endcase
        end
    end

    // Separate receiver and transmitter enables
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_on_r <= 1'b0;
            tx_on_r <= 1'b0;
        end else begin
            rx_on_r <= reg_on_r && opc_r[OPC_RX_BIT];
            // Field only once the clock is stable and crystal fits
            tx_on_r <= osc_stable_r && opc_r[OPC_TX_BIT] && !xtal_err_r;
        end
    end

    // Regulator voltage: adjust under load or direct write
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            adj_r      <= ADJ_IDLE;
            load_cnt_r <= '0;
            load_max_r <= 1'b0;
            reg_mv_r   <= REG_MV_RESET;
        end else begin
            case (adj_r)
                ADJ_IDLE: begin
                    if (reg_adjust_cmd && reg_on_r) begin
                        adj_r      <= ADJ_LOAD;
                        load_cnt_r <= '0;
                        load_max_r <= 1'b1;
                    end else if (reg_wr) begin
                        reg_mv_r   <= reg_wdata;
                    end
                end
                ADJ_LOAD: begin
                    if (!reg_on_r) begin
                        adj_r      <= ADJ_IDLE;   // Aborted by power-down
                        load_max_r <= 1'b0;
                    end else if (load_cnt_r == LOAD_CNT_LAST) begin
                        adj_r      <= ADJ_IDLE;
                        load_max_r <= 1'b0;
                        reg_mv_r   <= (vdd_mv > REG_DROP_MV) ? vdd_mv - REG_DROP_MV
                                                             : REG_MV_RESET;
                    end else begin
                        load_cnt_r <= load_cnt_r + 8'h01;
                    end
                end
                default: adj_r <= ADJ_IDLE;
            endcase
        end
    end

    // Wake-up timer runs only in wake-up mode
    assign wk.run    = (mode_r == MODE_WAKEUP);
    assign wk.period = wake_period;

    wakeup_timer u_timer (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .rc_tick (rc_tick),
        .wk      (wk)
    );

    // Measurement request per timer tick
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meas_req_r <= 1'b0;
        end else begin
            meas_req_r <= wk.tick;
        end
    end

    // Capacitive reference captured on calibration
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cap_ref_r <= CAP_REF_RESET;
        end else if (cap_cal_cmd && meas_done) begin
            cap_ref_r <= cap_val;
        end
    end

    // Compare results against references
    assign cap_lim   = {1'b0, cap_ref_r} + {1'b0, cap_thr};
    assign cap_hit   = {1'b0, cap_val} > cap_lim;
    assign phase_hit = ((phase_val > phase_ref) ? phase_val - phase_ref
                                                : phase_ref - phase_val) > delta_thr;
    assign amp_hit   = ((amp_val > amp_ref) ? amp_val - amp_ref
                                            : amp_ref - amp_val) > delta_thr;

    // Presence interrupt in wake-up mode
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_wake_r <= 1'b0;
        end else begin
            irq_wake_r <= (mode_r == MODE_WAKEUP) && meas_done && !cap_cal_cmd
                          && (cap_hit || phase_hit || amp_hit);
        end
    end

    // External field detector, both thresholds
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            peer_det_r <= 1'b0;
            coll_det_r <= 1'b0;
        end else begin
            peer_det_r <= field_level > peer_thr;
            coll_det_r <= field_level > coll_thr;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_supply_low_clear: assert property (supply_low |=> opc_r == OPC_RESET)
        else $error("Control word kept on low supply");
    a_write_in_pwrdn: assert property (opc_wr && !supply_low |=> opc_r == $past(opc_wdata))
        else $error("Control write lost");
    a_enable_ready: assert property (opc_r[OPC_EN_BIT] |=> mode_r == MODE_READY && osc_on_r)
        else $error("Enable did not reach ready");
    a_irq_after_ok: assert property (osc_on_r && osc_amp_ok && !osc_stable_r |=> osc_stable_r ##1 irq_osc_r)
        else $error("Stable interrupt missing");
    a_no_early_stable: assert property ($rose(osc_stable_r) |-> $past(osc_amp_ok))
        else $error("Stable without amplitude");
    a_tx_gated: assert property (tx_on_r |-> $past(osc_stable_r) && !$past(xtal_err_r))
        else $error("Field on before stable clock");
    a_xtal_check: assert property (very_high_bit_rate && !xtal_27m |=> xtal_err_r)
        else $error("Crystal mismatch not flagged");
    a_clk_off: assert property (!osc_stable_r |=> !mcu_clk_r)
        else $error("Controller clock ran before stable");
    a_rx_alone: assert property (reg_on_r && opc_r[OPC_RX_BIT] |=> rx_on_r)
        else $error("Receiver not enabled");
    a_wake_mode: assert property (opc_r == OPC_WU_ONLY |=> mode_r == MODE_WAKEUP)
        else $error("Wake-up mode not entered");
    a_wake_irq: assert property (irq_wake_r |-> $past(mode_r == MODE_WAKEUP && meas_done))
        else $error("Presence interrupt out of mode");
    a_cap_cal: assert property (cap_cal_cmd && meas_done |=> cap_ref_r == $past(cap_val))
        else $error("Capacitive reference not stored");
    a_adjust_done: assert property (adj_r == ADJ_LOAD && reg_on_r && load_cnt_r == LOAD_CNT_LAST
        && vdd_mv > REG_DROP_MV |=> reg_mv_r == $past(vdd_mv) - REG_DROP_MV)
        else $error("Adjusted voltage wrong");
    a_manual_write: assert property (adj_r == ADJ_IDLE && reg_wr && !(reg_adjust_cmd && reg_on_r)
        |=> reg_mv_r == $past(reg_wdata))
        else $error("Manual voltage not taken");
    a_peer_detect: assert property (field_level > peer_thr |=> peer_det_r)
        else $error("Peer field missed");
endmodule
`default_nettype wire

/* core/wake_if.sv */
// Link between the mode controller and its wake-up timer.
// Assumes both ends share clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface wake_if;
    logic       run;      // Timer armed (wake-up mode)
    logic [7:0] period;   // RC ticks between measurements, minus one
    logic       tick;     // One-cycle measurement request
    modport ctrl  (output run, output period, input tick);
    modport timer (input run, input period, output tick);
endinterface
`default_nettype wire

/* core/wakeup_timer.sv */
// Wake-up timer counting low-power RC oscillator ticks.
// Assumes rc_tick is a one-cycle pulse synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module wakeup_timer
    import pwr_mode_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic rc_tick,
    wake_if.timer     wk
);
    logic [WU_PER_W-1:0] cnt_r;   // RC ticks seen this period
    logic                tick_r;  // Registered request

    // Count RC ticks while armed, request on period end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (!wk.run) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (rc_tick && cnt_r >= wk.period) begin
            cnt_r  <= '0;   // Period reached
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= rc_tick ? cnt_r + 1'b1 : cnt_r;
            tick_r <= 1'b0;
        end
    end

    assign wk.tick = tick_r;

    a_tick_needs_run: assert property (@(posedge clk_sys) disable iff (!nrst)
        tick_r |-> $past(wk.run)) else $error("Timer ticked while idle");
endmodule
`default_nettype wire

/* tb/front_model.sv */
// Far-side model: crystal amplitude, RC oscillator ticks, host field gate.
// Assumes one clk_sys domain and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module front_model #(
    parameter int START_CYC = 12  // Crystal start-up length in cycles
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic osc_on,     // Oscillator enable from the device
    input  wire logic irq_osc,    // Stable interrupt from the device
    output logic      amp_ok,     // Amplitude criterion met
    output logic      rc_tick,    // One-cycle slow RC pulse
    output logic      field_ok    // Host may switch the field on
);
    logic [7:0] start_r;  // Start-up counter
    logic [2:0] rc_r;     // RC divider, one tick per 8 cycles
    // Amplitude builds only while the oscillator runs
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst || !osc_on) begin
            start_r <= 8'h00;
            amp_ok  <= 1'b0;
        end else if (start_r == 8'(START_CYC)) begin
            amp_ok <= 1'b1;
        end else begin
            start_r <= start_r + 8'h01;
        end
    end
    // Free running RC oscillator
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rc_r    <= 3'h0;
            rc_tick <= 1'b0;
        end else begin
            rc_r    <= rc_r + 3'h1;
            rc_tick <= (rc_r == 3'h7);
        end
    end
    // Field stays off until the stable interrupt arrives
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst || !osc_on) begin
            field_ok <= 1'b0;
        end else if (irq_osc) begin
            field_ok <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the reader power and mode controller.
// Assumes the design package and front_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import pwr_mode_pkg::*;
;
    logic clk_sys = 1'b0, nrst = 1'b0, supply_low = 1'b0, opc_wr = 1'b0;
    logic xtal_27m = 1'b1, very_high_bit_rate = 1'b0, reg_adjust_cmd = 1'b0;
    logic reg_wr = 1'b0, meas_done = 1'b0, cap_cal_cmd = 1'b0;
    logic osc_amp_ok, rc_tick, field_ok;
    logic [1:0] mcu_clk_sel = 2'h0;
    logic [7:0] opc_wdata = 8'h00, wake_period = 8'h02, cap_val = 8'h00;
    logic [7:0] cap_thr = 8'h10, phase_val = 8'h40, phase_ref = 8'h40;
    logic [7:0] amp_val = 8'h40, amp_ref = 8'h40, delta_thr = 8'h08;
    logic [7:0] field_level = 8'h00, peer_thr = 8'h30, coll_thr = 8'h60;
    logic [11:0] reg_wdata = 12'h000, vdd_mv = 12'h000;
    logic por_rst_r, osc_on_r, reg_on_r, gm_boost_r, osc_stable_r, irq_osc_r;
    logic xtal_err_r, mcu_clk_r, rx_on_r, tx_on_r, load_max_r, meas_req_r;
    logic irq_wake_r, peer_det_r, coll_det_r, mclk_q;
    logic [7:0] opc_r, cap_ref_r;
    logic [11:0] reg_mv_r;
    op_mode_t mode_r;
    int n_errors = 0, checks = 0, n_osc = 0, n_wake = 0, n_req = 0;
    int n_tog = 0, n_load = 0, i, k;
    // Wake table: capacitance, phase, amplitude, interrupt expected
    logic [7:0] w_cap [5] = '{8'h30, 8'h31, 8'h20, 8'h20, 8'h20};
    logic [7:0] w_ph  [5] = '{8'h40, 8'h40, 8'h49, 8'h40, 8'h48};
    logic [7:0] w_amp [5] = '{8'h40, 8'h40, 8'h40, 8'h37, 8'h38};
    logic       w_irq [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

    reader_power_mode_control dut_u (.*);
    front_model front_u (.clk_sys(clk_sys), .nrst(nrst), .osc_on(osc_on_r),
        .irq_osc(irq_osc_r), .amp_ok(osc_amp_ok), .rc_tick(rc_tick),
        .field_ok(field_ok));

    always #5 clk_sys = ~clk_sys;
    // Event counters for pulses, clock toggles and load cycles
    always @(posedge clk_sys) begin
        n_osc  += irq_osc_r;
        n_wake += irq_wake_r;
        n_req  += meas_req_r;
        n_load += load_max_r;
        n_tog  += (mcu_clk_r !== mclk_q);
        mclk_q = mcu_clk_r;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic wr_opc(input logic [7:0] v);
        @(posedge clk_sys);
        opc_wr    <= 1'b1;
        opc_wdata <= v;
        @(posedge clk_sys);
        opc_wr    <= 1'b0;
        #1;
    endtask
    task automatic meas(input logic [7:0] c, p, a, input logic cal);
        @(posedge clk_sys);
        meas_done   <= 1'b1;
        cap_val     <= c;
        phase_val   <= p;
        amp_val     <= a;
        cap_cal_cmd <= cal;
        @(posedge clk_sys);
        meas_done   <= 1'b0;
        cap_cal_cmd <= 1'b0;
        cyc(2);
    endtask
    // Adjust command, optionally with a direct write while it runs
    task automatic adjust(input logic [11:0] v, input logic mid,
                          input int exp_n, input logic [11:0] exp_mv);
        n_load = 0;
        @(posedge clk_sys);
        reg_adjust_cmd <= 1'b1;
        vdd_mv         <= v;
        @(posedge clk_sys);
        reg_adjust_cmd <= 1'b0;
        reg_wr         <= mid;
        reg_wdata      <= 12'h123;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        cyc(LOAD_SETTLE_CYC + 10);
        chk(n_load, exp_n, "load cycles");
        chk(reg_mv_r, exp_mv, "regulated mV");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog far beyond the expected run length
    initial begin
        #100000;
        n_errors++;
        $display("[FAIL] %0t watchdog", $time);
        stop_test;
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        cyc(2);
        chk(opc_r, OPC_RESET, "control word");
        chk(mode_r, MODE_PWRDN, "reset mode");
        chk(por_rst_r, 1'b0, "por after release");
        adjust(12'hce4, 1'b0, 0, REG_MV_RESET);
        $display("test reset done");
        wr_opc(8'h40);
        chk(opc_r, 8'h40, "write in power-down");
        cyc(3);
        chk(mode_r, MODE_PWRDN, "still power-down");
        chk(rx_on_r, 1'b0, "rx without regulators");
        $display("test power-down done");
        wr_opc(8'hc0);
        cyc(2);
        chk(mode_r, MODE_READY, "ready mode");
        chk(osc_on_r & reg_on_r, 1'b1, "osc and reg on");
        chk(gm_boost_r, 1'b1, "start-up boost");
        chk(field_ok, 1'b0, "field held off");
        for (i = 0; i < 100 && osc_stable_r !== 1'b1; i++) cyc(1);
        chk(n_osc, 0, "no irq before stable");
        cyc(3);
        chk(n_osc, 1, "one stable irq");
        chk(gm_boost_r, 1'b0, "boost ends");
        chk(field_ok, 1'b1, "field allowed");
        chk({rx_on_r, tx_on_r}, 2'h2, "rx alone");
        $display("test oscillator done");
        for (k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            mcu_clk_sel <= 2'(k);
            cyc(20);
            n_tog = 0;
            cyc(16);
            chk(n_tog, (k == 0) ? 0 : (32 >> k), "mcu clock rate");
        end
        $display("test mcu clock done");
        wr_opc(8'h88);
        cyc(3);
        chk({rx_on_r, tx_on_r}, 2'h1, "tx alone");
        @(posedge clk_sys);
        very_high_bit_rate <= 1'b1;
        xtal_27m           <= 1'b0;
        cyc(3);
        chk({xtal_err_r, tx_on_r}, 2'h2, "low crystal with very_high_bit_rate");
        @(posedge clk_sys);
        xtal_27m <= 1'b1;
        cyc(3);
        chk({xtal_err_r, tx_on_r}, 2'h1, "high crystal with very_high_bit_rate");
        $display("test enables done");
        adjust(12'hce4, 1'b1, LOAD_SETTLE_CYC, 12'hce4 - REG_DROP_MV);
        adjust(REG_DROP_MV, 1'b0, LOAD_SETTLE_CYC, 12'h000);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_wdata <= 12'hbb8;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
        chk(reg_mv_r, 12'hbb8, "direct regulator write");
        $display("test regulators done");
        for (k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            field_level <= (k == 0) ? 8'h40 : (k == 1) ? 8'h60 : 8'h61;
            cyc(2);
            chk({peer_det_r, coll_det_r}, (k == 2) ? 2'h3 : 2'h2, "field");
        end
        $display("test field done");
        @(posedge clk_sys);
        supply_low <= 1'b1;
        cyc(2);
        chk({por_rst_r, opc_r}, 9'h100, "low supply reset");
        wr_opc(8'h80);
        chk(opc_r, 8'h00, "write refused");
        @(posedge clk_sys);
        supply_low <= 1'b0;
        cyc(2);
        chk(por_rst_r, 1'b0, "supply back");
        $display("test supply done");
        wr_opc(8'h0c);
        cyc(2);
        chk(mode_r, MODE_PWRDN, "wake bit not alone");
        meas(8'h20, 8'h40, 8'h40, 1'b1);
        chk(cap_ref_r, 8'h20, "calibrated reference");
        wr_opc(OPC_WU_ONLY);
        cyc(2);
        chk(mode_r, MODE_WAKEUP, "wake-up mode");
        n_req = 0;
        cyc(60);
        chk(n_req != 0, 1'b1, "periodic measurement");
        for (k = 0; k < 5; k++) begin
            i = n_wake;
            meas(w_cap[k], w_ph[k], w_amp[k], 1'b0);
            chk(n_wake - i, 32'(w_irq[k]), "wake irq");
        end
        i = n_wake;
        meas(8'h90, 8'h40, 8'h40, 1'b1);
        chk(n_wake - i, 0, "no irq on calibration");
        wr_opc(8'h00);
        wr_opc(8'h80);
        cyc(2);
        chk(mode_r, MODE_READY, "back to ready");
        $display("test wake-up done");
        stop_test;
    end
endmodule
`default_nettype wire
